// *** xpc_host.sv ***
// Host controller that drives the crosspoint's parallel select pins.
// Assumes requests come from logic on this clock; the status pin from the
// device world passes a three-stage synchroniser.
//
// Behaviour
// - Channel code is four parallel bits
// - Power-down high enters shutdown, else low
// - Serial mode needs chip-enable, write, update high
// - Serial select held high in parallel mode
// - Serial entry only with all strobes high
module xpc_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Request side
    input wire logic req_valid,
    input wire logic [xpc_pkg::AMP_ADDR_W-1:0] req_amp,
    input wire logic [xpc_pkg::CHAN_CODE_W-1:0] req_code,
    input wire logic req_defer,
    input wire logic req_commit,
    input wire logic shutdown_req,
    output logic req_ready,
    output logic [xpc_pkg::CHAN_CODE_W*xpc_pkg::AMP_COUNT-1:0] amp_setting,
    output logic ext_fault,
    // Device pins
    input wire logic fault_pin,
    output logic chip_en_b,
    output logic write_b,
    output logic update_b,
    output logic serial_sel_b,
    output logic serial_din,
    output logic serial_clk,
    output logic power_down_in,
    output logic [xpc_pkg::AMP_ADDR_W-1:0] amp_addr,
    output logic [xpc_pkg::CHAN_CODE_W-1:0] chan_code
);

    // ==========================================================
    // Sequencer state
    // ==========================================================
    xpc_pkg::xpc_state_t state;
    xpc_pkg::xpc_state_t next_state;
    logic [xpc_pkg::TIMER_W-1:0] timer;
    logic [xpc_pkg::TIMER_W-1:0] next_timer;
    logic do_update;
    logic [xpc_pkg::CHAN_CODE_W*xpc_pkg::AMP_COUNT-1:0] pending;
    logic [2:0] fault_sync;

    wire logic timer_done = (timer == '0);
    wire logic take_req = req_ready & req_valid;
    wire logic [xpc_pkg::TIMER_W-1:0] addr_cyc =
        xpc_pkg::TIMER_W'(xpc_pkg::ADDR_SETUP_CYC - 1);
    wire logic [xpc_pkg::TIMER_W-1:0] write_cyc =
        xpc_pkg::TIMER_W'(xpc_pkg::WRITE_LOW_CYC - 1);
    wire logic [xpc_pkg::TIMER_W-1:0] update_cyc =
        xpc_pkg::TIMER_W'(xpc_pkg::UPDATE_LOW_CYC - 1);
    wire logic [xpc_pkg::TIMER_W-1:0] rest_cyc =
        xpc_pkg::TIMER_W'(xpc_pkg::UPDATE_TO_WRITE_CYC - 1);

    always_comb begin
        next_state = state;
        next_timer = timer_done ? timer : timer - 1'b1;
        case (state)
            xpc_pkg::XPC_IDLE: begin
                if (take_req) begin
                    next_state = xpc_pkg::XPC_ADDR;
                    next_timer = addr_cyc;
                end else if (req_commit) begin
                    next_state = xpc_pkg::XPC_UPDATE;
                    next_timer = update_cyc;
                end
            end
            xpc_pkg::XPC_ADDR: begin
                if (timer_done) begin
                    next_state = xpc_pkg::XPC_WRITE;
                    next_timer = write_cyc;
                end
            end
            xpc_pkg::XPC_WRITE: begin
                if (timer_done) begin
                    next_state = xpc_pkg::XPC_GAP;
                end
            end
            xpc_pkg::XPC_GAP: begin
                // Write rise precedes update fall; deferred writes stop here
                next_state = do_update ? xpc_pkg::XPC_UPDATE
                                       : xpc_pkg::XPC_REST;
                next_timer = do_update ? update_cyc : rest_cyc;
            end
            xpc_pkg::XPC_UPDATE: begin
                if (timer_done) begin
                    next_state = xpc_pkg::XPC_REST;
                    next_timer = rest_cyc;
                end
            end
            xpc_pkg::XPC_REST: begin
                if (timer_done) begin
                    next_state = xpc_pkg::XPC_IDLE;
                end
            end
            default: begin
                next_state = xpc_pkg::XPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= xpc_pkg::XPC_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ==========================================================
    // Request capture and pin drive
    // ==========================================================
    wire logic next_chip_en_b = !(next_state == xpc_pkg::XPC_ADDR ||
                                  next_state == xpc_pkg::XPC_WRITE);
    wire logic next_write_b = !(next_state == xpc_pkg::XPC_WRITE);
    wire logic next_update_b = !(next_state == xpc_pkg::XPC_UPDATE);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            chip_en_b <= 1'b1;
            write_b <= 1'b1;
            update_b <= 1'b1;
            amp_addr <= '0;
            chan_code <= xpc_pkg::CODE_DISABLED;
            do_update <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            chip_en_b <= next_chip_en_b;
            write_b <= next_write_b;
            update_b <= next_update_b;
            req_ready <= (next_state == xpc_pkg::XPC_IDLE) && !take_req;
            if (take_req) begin
                amp_addr <= req_amp;
                chan_code <= req_code;
                do_update <= !req_defer;
            end
        end
    end

    // Strap levels: parallel mode only, serial select parked high, serial data and clock low; power_down_in follows shutdown_req
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            serial_sel_b <= 1'b1;
            serial_din <= 1'b0;
            serial_clk <= 1'b0;
            power_down_in <= 1'b0;
        end else begin
            serial_sel_b <= 1'b1;
            serial_din <= 1'b0;
            serial_clk <= 1'b0;
            power_down_in <= shutdown_req;
        end
    end

    // ==========================================================
    // Shadow of the device's amplifier settings
    // ==========================================================
    // Pending mirrors the input latches, amp_setting the switch latches
    genvar g;
    for (g = 0; g < xpc_pkg::AMP_COUNT; g++) begin : g_amp
        localparam int LO = g * xpc_pkg::CHAN_CODE_W;
        wire logic sel = (amp_addr == xpc_pkg::AMP_ADDR_W'(g));
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                pending[LO +: xpc_pkg::CHAN_CODE_W] <= xpc_pkg::CODE_DISABLED;
                amp_setting[LO +: xpc_pkg::CHAN_CODE_W] <=
                    xpc_pkg::CODE_DISABLED;
            end else begin
                if (!write_b && !chip_en_b && sel) begin
                    pending[LO +: xpc_pkg::CHAN_CODE_W] <= chan_code;
                end
                if (!update_b) begin
                    amp_setting[LO +: xpc_pkg::CHAN_CODE_W] <=
                        pending[LO +: xpc_pkg::CHAN_CODE_W];
                end
            end
        end
    end

    // Three-stage sampler; second and third stages must agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_sync <= '0;
            ext_fault <= 1'b0;
        end else begin
            fault_sync <= {fault_sync[1:0], fault_pin};
            if (fault_sync[1] == fault_sync[2]) begin
                ext_fault <= fault_sync[2];
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    write_needs_ce_a: assert property (@(posedge clock) disable iff (!rst_b)
        !write_b |-> !chip_en_b)
        else $error("write low without chip enable");
    write_width_a: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(write_b) |-> !write_b [*5])
        else $error("write pulse too short");
    no_overlap_a: assert property (@(posedge clock) disable iff (!rst_b)
        !(!write_b && !update_b))
        else $error("write and update low together");
    update_width_a: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(update_b) |-> !update_b [*4])
        else $error("update pulse too short");
    serial_parked_a: assert property (@(posedge clock) disable iff (!rst_b)
        serial_sel_b && !serial_clk && !serial_din)
        else $error("serial pins not parked");
    addr_setup_a: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(write_b) |-> $stable(amp_addr) && $past(!chip_en_b))
        else $error("address not set up before write");
    update_copies_a: assert property (@(posedge clock) disable iff (!rst_b)
        !update_b |=> amp_setting == $past(pending))
        else $error("switch shadow did not follow input shadow");
    power_down_a: assert property (@(posedge clock) disable iff (!rst_b)
        shutdown_req |=> power_down_in)
        else $error("power down not driven");
    disabled_reset_a: assert property (@(posedge clock)
        !rst_b |-> update_b && serial_sel_b)
        else $error("strobes not high in reset");
    mode_strobes_a: assert property (@(posedge clock) disable iff (!rst_b)
        chip_en_b |-> write_b)
        else $error("write low while deselected");
    data_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        !write_b |-> $stable(chan_code))
        else $error("code moved during write");

    write_cov: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(write_b) ##1 !update_b);
    defer_cov: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(write_b) ##2 update_b);
    commit_cov: cover property (@(posedge clock) disable iff (!rst_b)
        req_commit && req_ready);
    disable_cov: cover property (@(posedge clock) disable iff (!rst_b)
        !write_b && chan_code[xpc_pkg::CODE_DISABLE_BIT]);

    // Shutdown does not block writes: the device loads inputs while down
    shutdown_write_cov: cover property (@(posedge clock)
        disable iff (!rst_b) power_down_in && !write_b);

endmodule

// *** xpc_pkg.sv ***
// Package for the crosspoint parallel-port host controller.
// Assumes a 100 MHz system clock; all pin timings are counted in cycles.
package xpc_pkg;

    // ==========================================================
    // Clock and pin timings
    // ==========================================================
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int ADDR_SETUP_NS = 20;
    localparam int WRITE_LOW_NS = 40;
    localparam int DATA_SETUP_NS = 50;
    localparam int UPDATE_LOW_NS = 40;
    localparam int UPDATE_TO_WRITE_NS = 25;
    localparam int ADDR_SETUP_CYC =
        (ADDR_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WRITE_LOW_RAW =
        (WRITE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DATA_SETUP_CYC =
        (DATA_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Write low must satisfy both pulse width and data setup to rise
    localparam int WRITE_LOW_CYC =
        (WRITE_LOW_RAW > DATA_SETUP_CYC) ? WRITE_LOW_RAW : DATA_SETUP_CYC;
    localparam int UPDATE_LOW_CYC =
        (UPDATE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int UPDATE_TO_WRITE_CYC =
        (UPDATE_TO_WRITE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int AMP_ADDR_W = 2;
    localparam int CHAN_CODE_W = 4;
    localparam int AMP_COUNT = 4;
    localparam int CODE_DISABLE_BIT = 3;
    localparam int TIMER_W = 4;
    localparam logic [CHAN_CODE_W-1:0] CODE_DISABLED = 4'h8;

    typedef enum logic [2:0] {
        XPC_IDLE,
        XPC_ADDR,
        XPC_WRITE,
        XPC_GAP,
        XPC_UPDATE,
        XPC_REST
    } xpc_state_t;

endpackage

// *** xpc_dev.sv ***
// Behavioural model of the crosspoint's parallel-mode latch banks.
// Assumes the host controller drives every strobe; no clock of its own.
module xpc_dev (
    // Strobes
    input wire logic chip_en_b,
    input wire logic write_b,
    input wire logic update_b,
    input wire logic serial_sel_b,
    input wire logic power_down_in,
    // Data
    input wire logic [1:0] amp_addr,
    input wire logic [3:0] chan_code,
    // Observed state
    output logic [15:0] in_vec,
    output logic [15:0] sw_vec,
    output logic [3:0] amp_on,
    output logic shut,
    output logic serial_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Latch banks
    // ==========================================================
    initial begin
        in_vec = 16'h8888;
        sw_vec = 16'h8888;
    end
    // Shutdown gates nothing here: input latches stay writable
    always @* begin
        if (!chip_en_b && !write_b) begin
            in_vec[{amp_addr, 2'h0} +: 4] = chan_code;
        end
    end
    always @* begin
        if (!update_b && serial_sel_b) begin
            sw_vec = in_vec;
        end
    end
    wire logic [3:0] off_bits = {sw_vec[15], sw_vec[11], sw_vec[7], sw_vec[3]};
    assign amp_on = ~off_bits;
    assign shut = power_down_in;
    // Serial shift path not modelled, only its entry condition
    wire logic strobes_idle = chip_en_b && write_b && update_b;
    assign serial_mode = !serial_sel_b && strobes_idle;
endmodule

// *** testbench.sv ***
// Self-checking bench for the crosspoint host controller.
// Assumes the latch model xpc_dev stands on the device pins.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_b, req_valid, req_defer, req_commit, shutdown_req;
    logic fault_pin, req_ready, ext_fault, chip_en_b, write_b, update_b;
    logic serial_sel_b, serial_din, serial_clk, power_down_in, shut;
    logic serial_mode;
    logic [1:0] req_amp, amp_addr;
    logic [3:0] req_code, chan_code, amp_on;
    logic [15:0] amp_setting, in_vec, sw_vec, exp_in, exp_sw;
    int err_count, cmp_count;
    xpc_host dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
        .req_amp(req_amp), .req_code(req_code), .req_defer(req_defer),
        .req_commit(req_commit), .shutdown_req(shutdown_req),
        .req_ready(req_ready), .amp_setting(amp_setting),
        .ext_fault(ext_fault), .fault_pin(fault_pin), .chip_en_b(chip_en_b),
        .write_b(write_b), .update_b(update_b), .serial_sel_b(serial_sel_b),
        .serial_din(serial_din), .serial_clk(serial_clk),
        .power_down_in(power_down_in), .amp_addr(amp_addr),
        .chan_code(chan_code));
    xpc_dev far (.chip_en_b(chip_en_b), .write_b(write_b),
        .update_b(update_b), .serial_sel_b(serial_sel_b),
        .power_down_in(power_down_in), .amp_addr(amp_addr),
        .chan_code(chan_code), .in_vec(in_vec), .sw_vec(sw_vec),
        .amp_on(amp_on), .shut(shut), .serial_mode(serial_mode));
    always #5 clock = ~clock;
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One write or a lone commit; strobe widths counted on the pins
    task run_req(input logic [1:0] amp, input logic [3:0] code,
                 input logic dfr, input logic cmt);
        int wr_n, up_n, i;
        logic [15:0] up_exp;
        wr_n = 0;
        up_n = 0;
        i = 0;
        @(posedge clock);
        while (req_ready !== 1'b1 && i < 50) begin
            @(posedge clock);
            i++;
        end
        req_valid <= !cmt;
        req_commit <= cmt;
        req_amp <= amp;
        req_code <= code;
        req_defer <= dfr;
        @(posedge clock);
        req_valid <= 1'b0;
        req_commit <= 1'b0;
        // Sample from the take edge on: a commit lowers update right there
        for (i = 0; i < 40; i++) begin
            #1;
            wr_n += (!write_b && !chip_en_b);
            up_n += !update_b;
            chk({14'h0, serial_mode, !serial_sel_b}, 16'h0);
            chk({14'h0, serial_clk, serial_din}, 16'h0);
            if (req_ready === 1'b1)
                break;
            @(posedge clock);
        end
        // A sequence that never returns to idle counts here
        chk({15'h0, req_ready}, 16'h1);
        if (!cmt)
            exp_in[{amp, 2'h0} +: 4] = code;
        if (!dfr || cmt)
            exp_sw = exp_in;
        chk(16'(wr_n), cmt ? 16'h0 : 16'(xpc_pkg::WRITE_LOW_CYC));
        up_exp = (dfr && !cmt) ? 16'h0 : 16'(xpc_pkg::UPDATE_LOW_CYC);
        chk(16'(up_n), up_exp);
        if (!cmt)
            chk({10'h0, amp_addr, chan_code}, {10'h0, amp, code});
        chk(in_vec, exp_in);
        chk(sw_vec, exp_sw);
        chk(amp_setting, exp_sw);
        chk({12'h0, amp_on}, {12'h0, ~exp_sw[15], ~exp_sw[11],
            ~exp_sw[7], ~exp_sw[3]});
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task t_reset;
        chk({12'h0, chip_en_b, write_b, update_b, serial_sel_b}, 16'hF);
        chk(sw_vec, 16'h8888);
        chk(amp_setting, 16'h8888);
        chk({12'h0, chan_code}, 16'h8);
    endtask
    // Every code 0..8 once, rotating over all four amplifiers
    task t_codes;
        int c;
        for (c = 0; c < 9; c++)
            run_req(2'(c % 4), 4'(c), 1'b0, 1'b0);
    endtask
    // Load all inputs, outputs stay put until one commit
    task t_batch;
        run_req(2'h0, 4'h6, 1'b1, 1'b0);
        run_req(2'h1, 4'hC, 1'b1, 1'b0);
        run_req(2'h2, 4'h2, 1'b1, 1'b0);
        run_req(2'h3, 4'h1, 1'b1, 1'b0);
        run_req(2'h0, 4'h0, 1'b0, 1'b1);
    endtask
    task t_shut;
        @(posedge clock);
        shutdown_req <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk({14'h0, power_down_in, shut}, 16'h3);
        run_req(2'h2, 4'h8, 1'b1, 1'b0);
        run_req(2'h0, 4'h0, 1'b0, 1'b1);
        @(posedge clock);
        shutdown_req <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk({15'h0, power_down_in}, 16'h0);
    endtask
    task t_fault;
        @(posedge clock);
        fault_pin <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        chk({15'h0, ext_fault}, 16'h1);
        @(posedge clock);
        fault_pin <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        chk({15'h0, ext_fault}, 16'h0);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        clock = 1'b0;
        // Start high so the fall below is an edge every process sees
        rst_b = 1'b1;
        {req_valid, req_defer, req_commit, shutdown_req, fault_pin} = 5'h0;
        req_amp = 2'h0;
        req_code = 4'h0;
        exp_in = 16'h8888;
        exp_sw = 16'h8888;
        err_count = 0;
        cmp_count = 0;
        #1;
        rst_b = 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        t_reset();
        t_codes();
        t_batch();
        t_shut();
        t_fault();
        test_done();
    end
    // Roughly 16 transfers of 16 cycles; ample margin beyond that
    initial begin
        #20000;
        err_count++;
        test_done();
    end
endmodule
